// ===== rtl/exec_pkg.sv
// Constants, types and register map for the increment/decrement, skip,
// literal-OR and branch execute block.
// Assumes one 25 MHz core clock and an APB master with 32-bit data.
package exec_pkg;

  // Widths
  localparam int DW    = 8;
  localparam int IW    = 16;
  localparam int PW    = 16;
  localparam int FAW   = 8;
  localparam int BR_KW = 13;
  localparam int APBAW = 8;
  localparam int APBDW = 32;

  // Instruction fields
  localparam int FILE_OPC_HI = 15;
  localparam int FILE_OPC_LO = 9;
  localparam int LIT_OPC_HI  = 15;
  localparam int LIT_OPC_LO  = 8;
  localparam int BR_OPC_HI   = 15;
  localparam int BR_OPC_LO   = 13;
  localparam int DEST_BIT    = 8;
  localparam int FILE_HI     = 7;
  localparam int FILE_LO     = 0;
  localparam int PCH_HI      = 15;
  localparam int PCH_LO      = 8;

  // Opcodes
  localparam logic [6:0] DEC_SKIP_NZ_OPC = 7'h13;
  localparam logic [6:0] INC_FILE_OPC    = 7'h0A;
  localparam logic [6:0] INC_SKIP_Z_OPC  = 7'h0F;
  localparam logic [6:0] INC_SKIP_NZ_OPC = 7'h12;
  localparam logic [7:0] OR_LIT_OPC      = 8'hB3;
  localparam logic [2:0] BRANCH_OPC      = 3'h6;

  // Register byte offsets
  localparam logic [APBAW-1:0] CTRL_OFS   = 8'h00;
  localparam logic [APBAW-1:0] W_OFS      = 8'h04;
  localparam logic [APBAW-1:0] FLAGS_OFS  = 8'h08;
  localparam logic [APBAW-1:0] PC_OFS     = 8'h0C;
  localparam logic [APBAW-1:0] LATCH_OFS  = 8'h10;
  localparam logic [APBAW-1:0] STATUS_OFS = 8'h14;

  // Register fields and reset values
  localparam int RUN_BIT     = 0;
  localparam int UNSUP_BIT   = 0;
  localparam int DISCARD_BIT = 1;
  localparam int FLAGS_W     = 4;
  localparam logic [DW-1:0] W_RST      = 8'h00;
  localparam logic [PW-1:0] PC_RST     = 16'h0000;
  localparam logic [DW-1:0] LATCH_RST  = 8'h00;
  localparam logic [IW-1:0] IR_RST     = 16'h0000;

  typedef enum logic {STAGE_RUN, STAGE_DISCARD} stage_e;

  typedef enum logic [2:0] {
    OP_NONE, OP_DEC_SKIP_NZ, OP_INC, OP_INC_SKIP_Z, OP_INC_SKIP_NZ, OP_OR_LIT, OP_BRANCH
  } op_e;

  typedef struct packed {
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } flags_s;

  typedef struct packed {
    logic           we;
    logic [FAW-1:0] addr;
    logic [DW-1:0]  data;
  } mem_wr_s;

endpackage

// ===== rtl/inc_dec_unit.sv
// Eight-bit plus-one / minus-one unit with carry, digit carry, overflow
// and zero. Pure combinational; the caller decides which flags it keeps.
module inc_dec_unit (
  // Operand
  input  wire logic [exec_pkg::DW-1:0] operand,
  input  wire logic                    dec,
  // Result
  output logic      [exec_pkg::DW-1:0] result,
  output exec_pkg::flags_s             flags
);
  import exec_pkg::*;

  logic [DW:0]  sum;
  logic [4:0]   low_sum;
  logic [DW-1:0] addend;

  // Minus one is plus all ones, so carry means no borrow
  assign addend  = dec ? {DW{1'b1}} : {{(DW-1){1'b0}}, 1'b1};
  assign sum     = {1'b0, operand} + {1'b0, addend};
  assign low_sum = {1'b0, operand[3:0]} + {1'b0, addend[3:0]};
  assign result  = sum[DW-1:0];

  always_comb begin
    flags.c                = sum[DW];
    flags.digit_carry_flag = low_sum[4];
    flags.z                = (sum[DW-1:0] == '0);
    flags.overflow_flag    = (operand[DW-1] == addend[DW-1]) && (sum[DW-1] != operand[DW-1]);
  end
endmodule

// ===== rtl/inc_dec_skip_or_unconditional_branch_op_exec.sv
// Execute stage for decrement-skip, increment, increment-skip, OR literal
// into the accumulator and the one-word branch, with its APB register file.
// Assumes fetch and data memory answer combinationally on the same clock.
module inc_dec_skip_or_unconditional_branch_op_exec (
  // Clock, reset, freeze
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    ce,
  // APB slave
  input  wire logic [exec_pkg::APBAW-1:0] paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [exec_pkg::APBDW-1:0] pwdata,
  output logic                         pready,
  output logic [exec_pkg::APBDW-1:0]   prdata,
  output logic                         pslverr,
  // Instruction fetch
  input  wire logic [exec_pkg::IW-1:0] fetch_word,
  output logic [exec_pkg::PW-1:0]      pc_out,
  // Data memory
  input  wire logic [exec_pkg::DW-1:0] mem_rdata,
  output logic [exec_pkg::FAW-1:0]     mem_raddr,
  output exec_pkg::mem_wr_s            mem_wr,
  // Core state
  output logic [exec_pkg::DW-1:0]      w_out,
  output exec_pkg::flags_s             flags_out,
  output logic [exec_pkg::DW-1:0]      pc_high_holding_latch,
  output logic                         discarding
);
  import exec_pkg::*;

  stage_e           stage_q;
  stage_e           stage_d;
  op_e              op;
  logic [IW-1:0]    ir_q;
  logic [DW-1:0]    w_q;
  flags_s           flags_q;
  logic [PW-1:0]    pc_q;
  logic [DW-1:0]    latch_q;
  logic             run_q;
  logic             unsup_q;
  mem_wr_s          wr_q;
  logic [APBDW-1:0] prdata_q;
  logic             err_q;
  logic [APBDW-1:0] rd_mux;
  logic             rd_hit;
  logic             sw_any;
  logic             exec_fire;
  logic             branch_fire;
  logic             skip;
  logic             file_op;
  logic             dest_file;
  logic             res_zero;
  logic [DW-1:0]    file_val;
  logic [DW-1:0]    alu_res;
  flags_s           alu_flags;
  logic [DW-1:0]    lit_k;
  logic [DW-1:0]    or_res;
  logic [PW-1:0]    branch_target;

  // Decode of the word in the execute stage
  always_comb begin
    op = OP_NONE;
    if (ir_q[BR_OPC_HI:BR_OPC_LO] == BRANCH_OPC) begin
      op = OP_BRANCH;
    end else if (ir_q[LIT_OPC_HI:LIT_OPC_LO] == OR_LIT_OPC) begin
      op = OP_OR_LIT;
    end else begin
      case (ir_q[FILE_OPC_HI:FILE_OPC_LO])
        DEC_SKIP_NZ_OPC: op = OP_DEC_SKIP_NZ;
        INC_FILE_OPC:    op = OP_INC;
        INC_SKIP_Z_OPC:  op = OP_INC_SKIP_Z;
        INC_SKIP_NZ_OPC: op = OP_INC_SKIP_NZ;
        default:         op = OP_NONE;
      endcase
    end
  end

  assign sw_any      = ce && psel && penable && pwrite;
  assign exec_fire   = ce && run_q && (stage_q == STAGE_RUN);
  assign branch_fire = exec_fire && (op == OP_BRANCH);
  assign file_op     = (op == OP_DEC_SKIP_NZ) || (op == OP_INC) || (op == OP_INC_SKIP_Z) || (op == OP_INC_SKIP_NZ);
  assign dest_file   = ir_q[DEST_BIT];
  assign mem_raddr   = ir_q[FILE_HI:FILE_LO];
  assign lit_k       = ir_q[FILE_HI:FILE_LO];

  // The write of the previous instruction lands a cycle late, so forward it
  assign file_val = (wr_q.we && (wr_q.addr == mem_raddr)) ? wr_q.data : mem_rdata;

  inc_dec_unit u_alu (
    .operand (file_val),
    .dec     (op == OP_DEC_SKIP_NZ),
    .result  (alu_res),
    .flags   (alu_flags)
  );

  assign or_res   = w_q | lit_k;
  assign res_zero = (alu_res == '0);

  assign skip = exec_fire && (((op == OP_DEC_SKIP_NZ) && !res_zero) ||
                              ((op == OP_INC_SKIP_Z) && res_zero) ||
                              ((op == OP_INC_SKIP_NZ) && !res_zero));

  // upper bits kept, low bits from the immediate
  assign branch_target = {pc_q[PW-1:BR_KW], ir_q[BR_KW-1:0]};

  // discard stage turns the prefetched word into a bubble
  always_comb begin
    case (stage_q)
      STAGE_RUN: begin
        if (skip || branch_fire || (sw_any && paddr == PC_OFS)) begin
          stage_d = STAGE_DISCARD;
        end else begin
          stage_d = STAGE_RUN;
        end
      end
      STAGE_DISCARD: begin
        // A stopped core keeps its bubble until it runs again
        if ((sw_any && paddr == PC_OFS) || !run_q) begin
          stage_d = STAGE_DISCARD;
        end else begin
          stage_d = STAGE_RUN;
        end
      end
      default: stage_d = STAGE_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_q <= STAGE_RUN;
    end else if (ce) begin
      stage_q <= stage_d;
    end
  end

  // Prefetch register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_q <= IR_RST;
    end else if (ce && run_q) begin
      ir_q <= fetch_word;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_q <= PC_RST;
    end else if (ce) begin
      if (sw_any && paddr == PC_OFS) begin
        pc_q <= pwdata[PW-1:0];
      end else if (branch_fire) begin
        pc_q <= branch_target;
      end else if (run_q) begin
        pc_q <= pc_q + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_q <= LATCH_RST;
    end else if (ce) begin
      if (sw_any && paddr == LATCH_OFS) begin
        latch_q <= pwdata[DW-1:0];
      end else if (branch_fire) begin
        latch_q <= branch_target[PCH_HI:PCH_LO];
      end
    end
  end

  // Accumulator; a software write in the same cycle wins over execution
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      w_q <= W_RST;
    end else if (ce) begin
      if (sw_any && paddr == W_OFS) begin
        w_q <= pwdata[DW-1:0];
      end else if (exec_fire && file_op && !dest_file) begin
        // destination 0 goes to the accumulator
        w_q <= alu_res;
      end else if (exec_fire && op == OP_OR_LIT) begin
        w_q <= or_res;
      end
    end
  end

  // Flags: skip instructions leave them untouched
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= '0;
    end else if (ce) begin
      if (sw_any && paddr == FLAGS_OFS) begin
        flags_q <= flags_s'(pwdata[FLAGS_W-1:0]);
      end else if (exec_fire && op == OP_INC) begin
        // all four flags from the adder
        flags_q <= alu_flags;
      end else if (exec_fire && op == OP_OR_LIT) begin
        flags_q.z <= (or_res == '0);
      end
    end
  end

  // destination 1 goes back to the file byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
    end else if (ce) begin
      wr_q.we   <= exec_fire && file_op && dest_file;
      wr_q.addr <= mem_raddr;
      wr_q.data <= alu_res;
    end
  end

  // Control and sticky status; a new unsupported word beats a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
    end else if (ce && sw_any && paddr == CTRL_OFS) begin
      run_q <= pwdata[RUN_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unsup_q <= 1'b0;
    end else if (ce) begin
      if (exec_fire && op == OP_NONE) begin
        unsup_q <= 1'b1;
      end else if (sw_any && paddr == STATUS_OFS && pwdata[UNSUP_BIT]) begin
        unsup_q <= 1'b0;
      end
    end
  end

  // APB read data is captured in setup so the access phase needs no wait
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (paddr)
      CTRL_OFS:   rd_mux[RUN_BIT] = run_q;
      W_OFS:      rd_mux[DW-1:0] = w_q;
      FLAGS_OFS:  rd_mux[FLAGS_W-1:0] = flags_q;
      PC_OFS:     rd_mux[PW-1:0] = pc_q;
      LATCH_OFS:  rd_mux[DW-1:0] = latch_q;
      STATUS_OFS: begin
        rd_mux[UNSUP_BIT]   = unsup_q;
        rd_mux[DISCARD_BIT] = (stage_q == STAGE_DISCARD);
      end
      default:    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= '0;
      err_q    <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata_q <= pwrite ? '0 : rd_mux;
      err_q    <= !rd_hit;
    end
  end

  assign pready                = psel && penable && ce;
  assign pslverr               = pready && err_q;
  assign prdata                = prdata_q;
  assign pc_out                = pc_q;
  assign mem_wr                = wr_q;
  assign w_out                 = w_q;
  assign flags_out             = flags_q;
  assign pc_high_holding_latch = latch_q;
  assign discarding            = (stage_q == STAGE_DISCARD);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  chk_dec_to_file: assert property (
    exec_fire && op == OP_DEC_SKIP_NZ && dest_file |=> wr_q.we && wr_q.data == $past(file_val) - 8'h01
  ) else $error("decrement result not written to file");

  chk_dest_to_w: assert property (
    exec_fire && file_op && !dest_file && !sw_any |=> w_q == $past(alu_res) && !wr_q.we
  ) else $error("destination 0 did not land in accumulator");

  chk_dec_skip: assert property (
    exec_fire && op == OP_DEC_SKIP_NZ && !res_zero |=> stage_q == STAGE_DISCARD
  ) else $error("nonzero decrement did not discard prefetch");

  chk_inc_flags: assert property (
    exec_fire && op == OP_INC && !sw_any |=> flags_q == $past(alu_flags)
  ) else $error("increment flags wrong");

  chk_inc_skip_zero: assert property (
    exec_fire && op == OP_INC_SKIP_Z && res_zero |=> stage_q == STAGE_DISCARD
  ) else $error("zero increment did not skip");

  chk_skip_nz_flags: assert property (
    exec_fire && op == OP_INC_SKIP_NZ && !sw_any |=> $stable(flags_q) && ((stage_q == STAGE_DISCARD) != $past(res_zero))
  ) else $error("skip-nonzero flags or skip wrong");

  chk_bubble_nop: assert property (
    stage_q == STAGE_DISCARD && ce && run_q && !sw_any |=> !wr_q.we && $stable(w_q) && $stable(flags_q) && stage_q == STAGE_RUN
  ) else $error("discarded word had an effect");

  chk_no_skip_one: assert property (
    exec_fire && op == OP_INC_SKIP_Z && !res_zero && !sw_any |=> stage_q == STAGE_RUN
  ) else $error("non-skipping increment took two cycles");

  chk_or_result: assert property (
    exec_fire && op == OP_OR_LIT && !sw_any |=> w_q == ($past(w_q) | $past(lit_k))
  ) else $error("literal OR result wrong");

  chk_or_zero_flag: assert property (
    exec_fire && op == OP_OR_LIT && !sw_any |=> flags_q.z == (w_q == '0) && flags_q.c == $past(flags_q.c) && stage_q == STAGE_RUN
  ) else $error("literal OR flags or timing wrong");

  chk_branch_load: assert property (
    branch_fire && !sw_any |=> pc_q[BR_KW-1:0] == $past(ir_q[BR_KW-1:0]) &&
                               pc_q[PW-1:BR_KW] == $past(pc_q[PW-1:BR_KW]) &&
                               latch_q == pc_q[PCH_HI:PCH_LO] && stage_q == STAGE_DISCARD
  ) else $error("branch did not load counter and latch");

  cov_dec_skip: cover property (skip && op == OP_DEC_SKIP_NZ);
  cov_branch:   cover property (branch_fire);
  cov_apb_read: cover property (pready && !pwrite && !pslverr);
  cov_skip_zero: cover property (skip && op == OP_INC_SKIP_Z);
  cov_unsup_op:  cover property (exec_fire && op == OP_NONE);
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the inc/dec skip, OR-literal and branch execute block.
// Assumes program and data memory answer combinationally; the bench models both.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;

  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic        err;
  } apb_note_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [3:0] gap;
  } wr_note_s;

  logic             clk, arst_n, ce, psel, penable, pwrite, pready, pslverr, discarding;
  logic [APBAW-1:0] paddr;
  logic [APBDW-1:0] pwdata, prdata;
  logic [IW-1:0]    fetch_word;
  logic [PW-1:0]    pc_out;
  logic [DW-1:0]    mem_rdata, w_out, pc_high_holding_latch;
  logic [FAW-1:0]   mem_raddr;
  mem_wr_s          mem_wr;
  flags_s           flags_out;
  logic [IW-1:0]    prog [256];
  logic [DW-1:0]    dmem [256];
  logic [7:0]       ofs [6];
  apb_note_s        apb_q[$];
  wr_note_s         wr_q[$];
  apb_note_s        an;
  wr_note_s         wn;
  int               errors, compares, cyc, last_wr;
  logic [7:0]       k, r;

  inc_dec_skip_or_unconditional_branch_op_exec uut (
    .clk(clk), .arst_n(arst_n), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .fetch_word(fetch_word), .pc_out(pc_out), .mem_rdata(mem_rdata), .mem_raddr(mem_raddr),
    .mem_wr(mem_wr), .w_out(w_out), .flags_out(flags_out),
    .pc_high_holding_latch(pc_high_holding_latch), .discarding(discarding)
  );

  // Memories answer in the same cycle, as the core expects
  assign fetch_word = prog[pc_out[7:0]];
  assign mem_rdata  = dmem[mem_raddr];

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Request held until the edge that samples pready; optional freeze in access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                     input logic [31:0] m, input logic err, input bit stall);
    apb_q.push_back('{e, m, err});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    if (stall) begin
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
    end
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0, 1'b0);
  endtask

  task automatic ew(input logic [7:0] a, input logic [7:0] d, input logic [3:0] g);
    wr_q.push_back('{a, d, g});
  endtask

  // Stopped core: a PC write throws away the stale prefetch
  task automatic run(input logic [15:0] start, input int n);
    wr(PC_OFS, {16'h0, start});
    @(negedge clk);
    chk("discarding", {31'h0, discarding}, 32'h1);
    wr(CTRL_OFS, 32'h1);
    repeat (n) @(posedge clk);
    wr(CTRL_OFS, 32'h0);
  endtask

  function automatic logic [15:0] fop(input logic [6:0] o, input logic dbit, input logic [7:0] f);
    return {o, dbit, f};
  endfunction

  // Result watcher: oldest note against each completed transfer or write pulse
  always @(posedge clk) begin
    cyc++;
    if (psel === 1'b1 && penable === 1'b1 && ce === 1'b0) chk("pready frozen", pready, 32'h0);
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      an = apb_q.pop_front();
      if (pwrite === 1'b0) chk("prdata", prdata & an.mask, an.data);
      chk("pslverr", pslverr, an.err);
    end
    if (mem_wr.we === 1'b1) begin
      dmem[mem_wr.addr] <= mem_wr.data;
      wn = wr_q.pop_front();
      chk("wr addr", mem_wr.addr, wn.addr);
      chk("wr data", mem_wr.data, wn.data);
      if (wn.gap != 4'h0) chk("wr gap", cyc - last_wr, {28'h0, wn.gap});
      last_wr = cyc;
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    $display("[ERR] watchdog expected end seen timeout");
    report_and_stop();
  end

  initial begin
    void'($urandom(31179));
    arst_n = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; errors = 0; compares = 0; cyc = 0; last_wr = 0;
    ofs = '{CTRL_OFS, W_OFS, FLAGS_OFS, PC_OFS, LATCH_OFS, STATUS_OFS};
    foreach (prog[i]) prog[i] = 16'hFFFF;
    foreach (dmem[i]) dmem[i] = 8'h00;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 32'h0, 32'hFFFF_FFFF);
    apb(1'b0, 8'h18, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1, 1'b0);
    k = 8'($urandom);
    wr(W_OFS, {24'hFF_FFFF, k});
    apb(1'b0, W_OFS, 32'h0, {24'h0, k}, 32'hFFFF_FFFF, 1'b0, 1'b1);
    wr(LATCH_OFS, 32'h5A);
    rd(LATCH_OFS, 32'h5A, 32'hFFFF_FFFF);
    wr(FLAGS_OFS, 32'h0);
    dmem[8'h20] = 8'h7F;
    k = 8'($urandom);
    prog[8'h00] = fop(INC_FILE_OPC, 1'b0, 8'h20);
    prog[8'h01] = fop(INC_SKIP_NZ_OPC, 1'b0, 8'h21);
    prog[8'h02] = {OR_LIT_OPC, 8'hFF};
    prog[8'h03] = {OR_LIT_OPC, k};
    prog[8'h04] = {BRANCH_OPC, 13'h0004};
    run(16'h0000, 10);
    rd(W_OFS, {24'h0, 8'h01 | k}, 32'hFF);
    rd(FLAGS_OFS, 32'hA, 32'hF);
    chk("w_out", {24'h0, w_out}, {24'h0, 8'h01 | k});
    chk("flags_out", {28'h0, flags_out}, 32'hA);
    // no skip on zero, OR sets only zero flag
    wr(W_OFS, 32'h5A);
    wr(FLAGS_OFS, 32'hB);
    dmem[8'h22] = 8'h01;
    prog[8'h08] = fop(DEC_SKIP_NZ_OPC, 1'b0, 8'h22);
    prog[8'h09] = {OR_LIT_OPC, 8'h00};
    prog[8'h0A] = {BRANCH_OPC, 13'h000A};
    run(16'h0008, 10);
    rd(W_OFS, 32'h0, 32'hFF);
    rd(FLAGS_OFS, 32'hF, 32'hF);
    r = 8'($urandom);
    dmem[8'h10] = 8'h33; dmem[8'h11] = 8'hFF; dmem[8'h12] = 8'h05; dmem[8'h13] = 8'hFF;
    dmem[8'h14] = 8'h07; dmem[8'h15] = 8'h01; dmem[8'h16] = 8'h09; dmem[8'h17] = r;
    prog[8'h40] = fop(INC_FILE_OPC, 1'b1, 8'h10);
    prog[8'h41] = fop(INC_SKIP_Z_OPC, 1'b1, 8'h11);
    prog[8'h42] = fop(INC_FILE_OPC, 1'b1, 8'h3F);
    prog[8'h43] = fop(INC_SKIP_Z_OPC, 1'b1, 8'h12);
    prog[8'h44] = fop(INC_SKIP_NZ_OPC, 1'b1, 8'h13);
    prog[8'h45] = fop(INC_SKIP_NZ_OPC, 1'b1, 8'h14);
    prog[8'h46] = fop(INC_FILE_OPC, 1'b1, 8'h3F);
    prog[8'h47] = fop(DEC_SKIP_NZ_OPC, 1'b1, 8'h15);
    prog[8'h48] = fop(DEC_SKIP_NZ_OPC, 1'b1, 8'h16);
    prog[8'h49] = fop(INC_FILE_OPC, 1'b1, 8'h3F);
    prog[8'h4A] = fop(INC_FILE_OPC, 1'b1, 8'h17);
    prog[8'h4B] = {BRANCH_OPC, 13'h004B};
    ew(8'h10, 8'h34, 4'h0); ew(8'h11, 8'h00, 4'h1);
    ew(8'h12, 8'h06, 4'h2); ew(8'h13, 8'h00, 4'h1);
    ew(8'h14, 8'h08, 4'h1); ew(8'h15, 8'h00, 4'h2);
    ew(8'h16, 8'h08, 4'h1); ew(8'h17, r + 8'h01, 4'h2);
    run(16'h0040, 20);
    chk("writes pending", wr_q.size(), 32'h0);
    // branch keeps top bits, fills latch, discards next word
    prog[8'hF0] = {BRANCH_OPC, 13'h1234};
    prog[8'hF1] = {OR_LIT_OPC, 8'h55};
    prog[8'h35] = {BRANCH_OPC, 13'h1235};
    run(16'hA0F0, 10);
    rd(LATCH_OFS, 32'hB2, 32'hFF);
    rd(PC_OFS, 32'hB200, 32'hFF00);
    chk("latch out", {24'h0, pc_high_holding_latch}, 32'hB2);
    chk("pc_out", {16'h0, pc_out[15:8], 8'h00}, 32'hB200);
    rd(W_OFS, 32'h0, 32'hFF);
    rd(STATUS_OFS, 32'h1, 32'h1);
    wr(STATUS_OFS, 32'h1);
    rd(STATUS_OFS, 32'h0, 32'h1);
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule
